// *** hdl/cs_hold_pkg.sv ***
// package: register map, field layout, reset values and cycle counts for carrier sense and hold
package cs_hold_pkg;
    localparam logic [7:0] CFG_INDEX        = 8'h11;
    localparam logic [7:0] CFG_ADDR         = 8'h44;
    localparam logic [7:0] STATUS_ADDR      = 8'h48;
    localparam logic [7:0] MASK_ADDR        = 8'h4c;
    localparam logic [7:0] STATE_ADDR       = 8'h50;
    localparam logic [7:0] CFG_RESET        = 8'h65;
    localparam int         SET_CNT_MSB      = 7;
    localparam int         SET_CNT_LSB      = 6;
    localparam int         DROP_CNT_BIT     = 5;
    localparam int         WAIT_MSB         = 4;
    localparam int         WAIT_LSB         = 2;
    localparam int         FREEZE_MSB       = 1;
    localparam int         FREEZE_LSB       = 0;
    localparam logic [2:0] WAIT_FOREVER     = 3'h7;
    localparam logic [7:0] FREEZE_BASE_CLKS = 8'h10;
    localparam int         IRQ_BITS         = 3;
    localparam int         IRQ_CS_RISE      = 0;
    localparam int         IRQ_CS_FALL      = 1;
    localparam int         IRQ_HOLD_DONE    = 2;
endpackage

// *** hdl/cs_hold_top.sv ***
// top: apb registers, clock enables, carrier-sense qualifier and freeze timer
// Function
// RULE1: assert sense after set-count+1 samples above
// RULE2: clear sense after one or two below
// RULE3: drive qualified sense onto status pin
// RULE4: freeze loops on gain-change trigger events
// RULE5: hold 16..48 filter clocks per code
// RULE6: hold code 7 freezes indefinitely
// RULE7: extra freeze 16/32/64/128 converter clocks
// RULE8: software should set drop count to 1
// RULE9: opposite-side sample restarts run counter
//
// Added by the designer: the APB slave port.
`timescale 1ns/1ps
module cs_hold_top #(
    parameter int FILT_DIV = 16,
    parameter int ADC_DIV  = 4
) (
    input  wire logic        CLK,
    input  wire logic        NRST,
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [7:0]  PADDR,
    input  wire logic [31:0] PWDATA,
    output logic      [31:0] PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    input  wire logic        SAMPLE_VALID,
    input  wire logic        LEVEL_ABOVE,
    input  wire logic        GAIN_CHANGE,
    output logic             CARRIER_SENSE,
    output logic             FREEZE,
    output logic             IRQ
);
    import cs_hold_pkg::*;

    typedef struct packed {
        logic [7:0]          cfg;
        logic [IRQ_BITS-1:0] status;
        logic [IRQ_BITS-1:0] mask;
        logic [15:0]         fdiv;
        logic [15:0]         adiv;
        logic                sense_prev;
        logic [31:0]         rdata;
        logic                ready;
        logic                slverr;
        logic                sense_out;
        logic                freeze_out;
        logic                irq;
    } state_type;
    state_type s_q, s_d;

    logic filt_en;
    logic adc_en;
    logic sense;
    logic frozen;
    logic hold_done;
    logic access;
    logic [IRQ_BITS-1:0] events;

    ////////////////////////////////////////////////////////////////////////////
    // slow rates as one-cycle enables
    assign filt_en = (s_q.fdiv == 16'(FILT_DIV - 1));
    assign adc_en  = (s_q.adiv == 16'(ADC_DIV - 1));

    cs_qualifier u_qual (
        .clk       (CLK),
        .nrst      (NRST),
        .sample_en (SAMPLE_VALID),
        .above     (LEVEL_ABOVE),
        .set_sel   (s_q.cfg[SET_CNT_MSB:SET_CNT_LSB]),
        .drop_sel  (s_q.cfg[DROP_CNT_BIT]),
        .sense     (sense)
    );

    freeze_timer u_freeze (
        .clk        (CLK),
        .nrst       (NRST),
        .trigger    (GAIN_CHANGE),
        .filt_en    (filt_en),
        .adc_en     (adc_en),
        .wait_sel   (s_q.cfg[WAIT_MSB:WAIT_LSB]),
        .freeze_sel (s_q.cfg[FREEZE_MSB:FREEZE_LSB]),
        .frozen     (frozen),
        .done       (hold_done)
    );

    ////////////////////////////////////////////////////////////////////////////
    // registers, events and apb
    assign access = PSEL && PENABLE && !s_q.ready;

    always_comb begin
        events = '0;
        events[IRQ_CS_RISE]   = sense && !s_q.sense_prev;
        events[IRQ_CS_FALL]   = !sense && s_q.sense_prev;
        events[IRQ_HOLD_DONE] = hold_done;
    end

    always_comb begin
        s_d = s_q;
        s_d.fdiv       = filt_en ? 16'h0 : s_q.fdiv + 16'h1;
        s_d.adiv       = adc_en ? 16'h0 : s_q.adiv + 16'h1;
        s_d.sense_prev = sense;
        s_d.ready      = 1'b0;
        s_d.slverr     = 1'b0;
        if (access) begin
            s_d.ready = 1'b1;
            s_d.rdata = 32'h0;
            unique case (PADDR)
                CFG_ADDR: begin
                    s_d.rdata = {24'h0, s_q.cfg};
                    if (PWRITE) begin
                        s_d.cfg = PWDATA[7:0];
                    end
                end
                STATUS_ADDR: begin
                    s_d.rdata = {29'h0, s_q.status};
                    if (PWRITE) begin
                        s_d.status = s_q.status & ~PWDATA[IRQ_BITS-1:0];
                    end
                end
                MASK_ADDR: begin
                    s_d.rdata = {29'h0, s_q.mask};
                    if (PWRITE) begin
                        s_d.mask = PWDATA[IRQ_BITS-1:0];
                    end
                end
                STATE_ADDR: s_d.rdata = {30'h0, frozen, sense};
                default:    s_d.slverr = 1'b1;
            endcase
        end
        // set wins over a same-cycle clear
        s_d.status     = s_d.status | events;
        s_d.sense_out  = sense; // [RULE3]
        s_d.freeze_out = frozen; // [RULE4]
        s_d.irq        = |(s_d.status & s_d.mask);
    end

    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            s_q <= '{cfg: CFG_RESET, default: '0};
        end else begin
            s_q <= s_d;
        end
    end

    assign PRDATA        = s_q.rdata;
    assign PREADY        = s_q.ready;
    assign PSLVERR       = s_q.slverr;
    assign CARRIER_SENSE = s_q.sense_out;
    assign FREEZE        = s_q.freeze_out;
    assign IRQ           = s_q.irq;
endmodule

// *** hdl/cs_qualifier.sv ***
// consecutive-sample qualifier that sets and clears carrier sense
`timescale 1ns/1ps
module cs_qualifier (
    input  wire logic       clk,
    input  wire logic       nrst,
    input  wire logic       sample_en,
    input  wire logic       above,
    input  wire logic [1:0] set_sel,
    input  wire logic       drop_sel,
    output logic            sense
);
    import cs_hold_pkg::*;
    typedef struct packed {
        logic [1:0] run;
        logic       sense;
    } state_type;
    state_type s_q, s_d;

    always_comb begin
        s_d = s_q;
        if (sample_en) begin
            if (s_q.sense == above) begin
                s_d.run = 2'h0; // [RULE9]
            end else if (!s_q.sense) begin
                if (s_q.run >= set_sel) begin
                    s_d.sense = 1'b1; // [RULE1]
                    s_d.run   = 2'h0;
                end else begin
                    s_d.run = s_q.run + 2'h1;
                end
            end else begin
                if (s_q.run >= {1'b0, drop_sel}) begin
                    s_d.sense = 1'b0; // [RULE2]
                    s_d.run   = 2'h0;
                end else begin
                    s_d.run = s_q.run + 2'h1;
                end
            end
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end
    assign sense = s_q.sense;
endmodule

// *** hdl/freeze_timer.sv ***
// freeze timer: filter-clock hold then converter-clock extra interval
`timescale 1ns/1ps
module freeze_timer (
    input  wire logic       clk,
    input  wire logic       nrst,
    input  wire logic       trigger,
    input  wire logic       filt_en,
    input  wire logic       adc_en,
    input  wire logic [2:0] wait_sel,
    input  wire logic [1:0] freeze_sel,
    output logic            frozen,
    output logic            done
);
    import cs_hold_pkg::*;
    typedef enum logic [1:0] {IDLE, HOLD, EXTRA} phase_type;
    typedef struct packed {
        phase_type  phase;
        logic [7:0] cnt;
        logic       done;
    } state_type;
    state_type s_q, s_d;
    logic [7:0] hold_len;

    always_comb begin
        unique case (wait_sel) // [RULE5]
            3'h0: hold_len = 8'h10;
            3'h1: hold_len = 8'h14;
            3'h2: hold_len = 8'h18;
            3'h3: hold_len = 8'h1c;
            3'h4: hold_len = 8'h20;
            3'h5: hold_len = 8'h28;
            3'h6: hold_len = 8'h30;
            default: hold_len = 8'h30;
        endcase
    end

    always_comb begin
        s_d = s_q;
        s_d.done = 1'b0;
        if (trigger) begin
            s_d.phase = HOLD; // [RULE4]
            s_d.cnt   = 8'h0;
        end else begin
            unique case (s_q.phase)
                IDLE: begin
                end
                HOLD: begin
                    if (wait_sel == WAIT_FOREVER) begin
                        s_d.cnt = 8'h0; // [RULE6]
                    end else if (filt_en) begin
                        if (s_q.cnt + 8'h1 >= hold_len) begin
                            s_d.phase = EXTRA; // [RULE7]
                            s_d.cnt   = 8'h0;
                        end else begin
                            s_d.cnt = s_q.cnt + 8'h1;
                        end
                    end
                end
                EXTRA: begin
                    // code 7 written during the extra interval still holds, no timeout
                    if (adc_en && wait_sel != WAIT_FOREVER) begin // [RULE6]
                        if (s_q.cnt + 8'h1 >= (FREEZE_BASE_CLKS << freeze_sel)) begin
                            s_d.phase = IDLE; // [RULE7]
                            s_d.cnt   = 8'h0;
                            s_d.done  = 1'b1;
                        end else begin
                            s_d.cnt = s_q.cnt + 8'h1;
                        end
                    end
                end
                default: s_d.phase = IDLE;
            endcase
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            s_q <= '{phase: IDLE, cnt: 8'h0, done: 1'b0};
        end else begin
            s_q <= s_d;
        end
    end
    assign frozen = (s_q.phase != IDLE);
    assign done   = s_q.done;
endmodule

// *** tb/cs_hold_asserts.sv ***
// checker: port-level assertions for the carrier sense and hold block
`timescale 1ns/1ps
module cs_hold_asserts import cs_hold_pkg::*; #(
    parameter int FILT_DIV = 16,
    parameter int ADC_DIV  = 4
) (
    input wire logic        CLK,
    input wire logic        NRST,
    input wire logic        PSEL,
    input wire logic        PENABLE,
    input wire logic        PWRITE,
    input wire logic [7:0]  PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic        PREADY,
    input wire logic        PSLVERR,
    input wire logic        SAMPLE_VALID,
    input wire logic        LEVEL_ABOVE,
    input wire logic        GAIN_CHANGE,
    input wire logic        CARRIER_SENSE,
    input wire logic        FREEZE
);
    localparam int FRZ_MAX = 50 * FILT_DIV + 130 * ADC_DIV + 8;
    logic [2:0] hi_q;
    logic [2:0] lo_q;
    logic [7:0] cfg_q;
    int         frz_q;
    wire        wr    = PSEL & PENABLE & PWRITE & ~PREADY & (PADDR == CFG_ADDR);
    wire        hold7 = cfg_q[WAIT_MSB:WAIT_LSB] == WAIT_FOREVER;
    // shadow of the config, updated at the same edge as the write lands
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            hi_q  <= 3'h0;
            lo_q  <= 3'h0;
            cfg_q <= CFG_RESET;
            frz_q <= 0;
        end else begin
            hi_q  <= {hi_q[1:0], SAMPLE_VALID & LEVEL_ABOVE};
            lo_q  <= {lo_q[1:0], SAMPLE_VALID & ~LEVEL_ABOVE};
            cfg_q <= wr ? PWDATA[7:0] : cfg_q;
            frz_q <= (!FREEZE || GAIN_CHANGE || hold7) ? 0 : frz_q + 1;
        end
    end
    ////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!NRST);
    a_sense_rise: assert property ($rose(CARRIER_SENSE) |-> |hi_q)
        else $error("sense rose without above sample");
    a_sense_fall: assert property ($fell(CARRIER_SENSE) |-> |lo_q)
        else $error("sense fell without below sample");
    a_sense_steady: assert property (!(|{hi_q, lo_q}) |-> $stable(CARRIER_SENSE))
        else $error("sense moved with no sample");
    a_freeze_start: assert property (GAIN_CHANGE |-> ##[1:3] FREEZE)
        else $error("no freeze after gain change");
    a_freeze_min: assert property ($rose(FREEZE) |-> FREEZE [*8])
        else $error("freeze too short");
    a_hold_forever: assert property (FREEZE && hold7 && !GAIN_CHANGE && !wr |=> FREEZE)
        else $error("unconditional hold ended");
    a_freeze_bound: assert property (frz_q < FRZ_MAX)
        else $error("freeze too long");
    a_apb_ready: assert property (PSLVERR |-> PREADY ##1 !PREADY)
        else $error("bad apb answer");
    c_sense: cover property ($rose(CARRIER_SENSE));
    c_freeze: cover property ($fell(FREEZE));
    c_slverr: cover property (PSLVERR);
endmodule
bind cs_hold_top cs_hold_asserts #(.FILT_DIV(FILT_DIV), .ADC_DIV(ADC_DIV)) chk (
    .CLK(CLK), .NRST(NRST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
    .PWDATA(PWDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .SAMPLE_VALID(SAMPLE_VALID),
    .LEVEL_ABOVE(LEVEL_ABOVE), .GAIN_CHANGE(GAIN_CHANGE), .CARRIER_SENSE(CARRIER_SENSE),
    .FREEZE(FREEZE));

// *** tb/cs_hold_top_test.sv ***
// testbench: apb, carrier sense and freeze scenarios for cs_hold_top
`timescale 1ns/1ps
module cs_hold_top_test;
    import cs_hold_pkg::*;
    logic        clk = 0, nrst = 0, psel = 0, pen = 0, pwr = 0, sv = 0, la = 0, gc = 0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd, wv, seed = 32'h15;
    logic        pready, pslverr, cs, frz, irq, err;
    logic [1:0]  f;
    int          num_errors = 0, samples_checked = 0, n;
    always #2 clk = ~clk;
    // short divisors keep every freeze count in clock cycles
    cs_hold_top #(.FILT_DIV(1), .ADC_DIV(1)) uut (
        .CLK(clk), .NRST(nrst), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr), .PADDR(paddr),
        .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
        .SAMPLE_VALID(sv), .LEVEL_ABOVE(la), .GAIN_CHANGE(gc), .CARRIER_SENSE(cs),
        .FREEZE(frz), .IRQ(irq));
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    function automatic int frz_len(input int w, input logic [1:0] x);
        int h[7] = '{16, 20, 24, 28, 32, 40, 48};
        return h[w] + (16 << x);
    endfunction
    ////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED %0t %s", $time, m);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel   <= 1'b1;
        pwr    <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd  = prdata;
        err = pslverr;
        psel <= 1'b0;
        pen  <= 1'b0;
    endtask
    // level is noise between samples: only the sampled cycle may count
    task automatic smp(input logic a, input int k);
        repeat (k) begin
            @(posedge clk);
            sv <= 1'b1;
            la <= a;
            @(posedge clk);
            sv <= 1'b0;
            la <= ^xs();
            repeat (3) @(posedge clk);
        end
        #1;
    endtask
    task automatic end_of_test();
        $display("checks %0d errors %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        #80000;
        num_errors++;
        end_of_test();
    end
    initial begin
        repeat (10) @(posedge clk);
        nrst <= 1'b1;
        apb(0, CFG_ADDR, 32'h0);
        chk(rd, {24'h0, CFG_RESET}, "cfg reset");
        apb(0, 8'h00, 32'h0);
        chk(32'(err), 32'h1, "unmapped");
        wv = xs();
        apb(1, CFG_ADDR, wv);
        apb(0, CFG_ADDR, 32'h0);
        chk(rd, {24'h0, wv[7:0]}, "cfg rw");
        apb(1, STATUS_ADDR, 32'h7);
        apb(1, MASK_ADDR, 32'h0);
        $display("test apb done");
        for (int s = 0; s < 4; s++) for (int d = 0; d < 2; d++) begin
            apb(1, CFG_ADDR, 32'(s * 64 + d * 32));
            smp(0, 2);
            smp(1, s);
            smp(0, 1);
            smp(1, s);
            chk(32'(cs), 32'h0, "early set");
            smp(1, 1);
            chk(32'(cs), 32'h1, "set");
            if (d) smp(0, 1);
            if (d) smp(1, 1);
            smp(0, d);
            chk(32'(cs), 32'h1, "early clear");
            smp(0, 1);
            chk(32'(cs), 32'h0, "clear");
        end
        apb(0, STATUS_ADDR, 32'h0);
        chk(rd & 32'h7, 32'h3, "status");
        apb(1, MASK_ADDR, 32'h1);
        repeat (2) @(posedge clk);
        #1 chk(32'(irq), 32'h1, "irq");
        apb(1, STATUS_ADDR, 32'h1);
        repeat (2) @(posedge clk);
        #1 chk(32'(irq), 32'h0, "irq clear");
        $display("test sense done");
        for (int w = 0; w < 7; w++) begin
            f = 2'(xs());
            apb(1, CFG_ADDR, 32'(w * 4 + f));
            @(posedge clk);
            gc <= 1'b1;
            @(posedge clk);
            gc <= 1'b0;
            repeat (3) @(posedge clk);
            for (n = 0; frz === 1'b1 && n < 400; n++) @(posedge clk);
            chk(32'(n + 4 >= frz_len(w, f) && n <= frz_len(w, f) + 4), 32'h1, "len");
        end
        apb(1, STATUS_ADDR, 32'h4);
        apb(1, CFG_ADDR, 32'h3c);
        gc <= 1'b1;
        @(posedge clk);
        gc <= 1'b0;
        repeat (200) @(posedge clk);
        #1 chk(32'(frz), 32'h1, "hold forever");
        apb(0, STATE_ADDR, 32'h0);
        chk(rd, 32'h2, "state frozen");
        apb(0, STATUS_ADDR, 32'h0);
        chk(rd & 32'h4, 32'h0, "done while held");
        apb(1, CFG_ADDR, 32'h20);
        repeat (60) @(posedge clk);
        #1 chk(32'(frz), 32'h0, "hold released");
        apb(0, STATUS_ADDR, 32'h0);
        chk(rd & 32'h4, 32'h4, "freeze done");
        $display("test freeze done");
        end_of_test();
    end
endmodule
